/* File: common/timer_map.svh */
// Register offsets, field positions, reset values and counts for the timer pair.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define OFS_CFG 12'h000
`define OFS_AMODE 12'h004
`define OFS_BMODE 12'h008
`define OFS_CTL 12'h00C
`define OFS_IMR 12'h018
`define OFS_RIS 12'h01C
`define OFS_MIS 12'h020
`define OFS_ICR 12'h024
`define OFS_AILR 12'h028
`define OFS_BILR 12'h02C
`define OFS_AMAT 12'h030
`define OFS_BMAT 12'h034
`define OFS_APR 12'h038
`define OFS_BPR 12'h03C
`define OFS_ACNT 12'h048
`define OFS_BCNT 12'h04C

`define CFG_32 3'h0
`define CFG_RTC 3'h1
`define CFG_16 3'h4
`define MODE_ONESHOT 2'h1
`define MODE_PERIODIC 2'h2
`define MODE_CAPTURE 2'h3
`define EVT_RISE 2'h0
`define EVT_FALL 2'h1
`define EVT_BOTH 2'h3

`define CTL_EN 0
`define CTL_STALL 1
`define CTL_EVT 2
`define CTL_CLK_STALL 4
`define CTL_INV 6
`define HALF_STEP 8
`define CTL_BITS 16'h4F5F

`define RIS_TO 0
`define RIS_CM 1
`define RIS_CE 2
`define RIS_RTC 3
`define RIS_BITS 16'h070F

`define CNT_RST 16'hFFFF
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT32_ZERO 32'h0000_0000
`define CNT32_ONE 32'h0000_0001
`define RTC_FIRST 32'h0000_0001
`define RTC_DIV_LAST 15'h7FFF
`define RTC_DIV_ONE 15'h0001
`define PS_ONE 8'h01

`endif

/* File: common/timer_pkg.sv */
// Types shared by the timer pair top level and its timer halves.
package timer_pkg;

    typedef enum {HM_IDLE, HM_TIMER, HM_COUNT, HM_TIME, HM_PWM} half_mode_t;

    typedef struct packed {
        logic alternate_mode_select;
        logic capture_mode_select;
        logic [1:0] timer_mode_field;
    } mode_reg_t;

    typedef struct packed {
        logic sixteen;
        logic enable;
        mode_reg_t mode;
        logic [1:0] edge_event_select;
        logic pulse_output_invert;
        logic [15:0] interval_load_value;
        logic [15:0] match_value;
        logic [7:0] prescale_value;
        logic load_strobe;
    } half_cfg_t;

    typedef struct packed {
        logic timeout;
        logic match;
        logic capture;
        logic stop;
        logic rise;
    } half_evt_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic level;
        logic pin_out;
        logic pin_oe;
        logic [15:0] count;
        logic [15:0] captured;
        logic [7:0] ps;
        half_evt_t evt;
    } half_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [2:0] cfg;
        mode_reg_t [1:0] hmode;
        logic [15:0] ctl;
        logic [15:0] imr;
        logic [15:0] ris;
        logic [1:0][15:0] ilr;
        logic [1:0][15:0] mat;
        logic [1:0][7:0] pr;
        logic [1:0] ld;
        logic [31:0] cnt32;
        logic [14:0] div;
        logic [31:0] prdata;
        logic slverr;
    } main_state_t;

endpackage : timer_pkg

/* File: hw/timer_half.sv */
// One 16-bit timer half: timer, edge count, edge time and pulse output.
`timescale 1ns/10ps
`include "timer_map.svh"

module timer_half (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Settings from the register file
    input wire timer_pkg::half_cfg_t cfg,
    // Capture/compare pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Count view and event pulses
    output logic [15:0] count_view,
    output timer_pkg::half_evt_t evt
);
    import timer_pkg::*;

    half_state_t s;
    half_state_t n;
    half_mode_t mode;
    logic rise;
    logic fall;
    logic hit;
    logic [15:0] dec;

    // Decode the operating mode; outside the 16-bit setup the half sleeps.
    always_comb begin
        if (!cfg.sixteen) begin
            mode = HM_IDLE;
        end else if (cfg.mode.alternate_mode_select && !cfg.mode.capture_mode_select &&
                     cfg.mode.timer_mode_field == `MODE_PERIODIC) begin
            mode = HM_PWM;
        end else if (cfg.mode.timer_mode_field == `MODE_CAPTURE) begin
            mode = cfg.mode.capture_mode_select ? HM_TIME : HM_COUNT;
        end else if (cfg.mode.timer_mode_field == `MODE_ONESHOT ||
                     cfg.mode.timer_mode_field == `MODE_PERIODIC) begin
            mode = HM_TIMER;
        end else begin
            mode = HM_IDLE;
        end
    end

    // Edges come from the last two synchronised samples only.
    assign rise = s.sync2 && !s.prev;
    assign fall = !s.sync2 && s.prev;
    assign hit = (rise && (cfg.edge_event_select == `EVT_RISE || cfg.edge_event_select == `EVT_BOTH)) ||
                 (fall && (cfg.edge_event_select == `EVT_FALL || cfg.edge_event_select == `EVT_BOTH));
    assign dec = s.count - `CNT_ONE;

    // Next state of the half.
    always_comb begin
        n = s;
        n.evt = '0;
        n.sync1 = pin_in;
        n.sync2 = s.sync1;
        n.prev = s.sync2;
        n.evt.rise = rise;
        if (cfg.load_strobe) begin
            // A new load value takes over one cycle after the write.
            n.count = cfg.interval_load_value;
        end else if (cfg.enable) begin
            unique case (mode)
                HM_TIMER: begin
                    if (s.ps != '0) begin
                        n.ps = s.ps - `PS_ONE;
                    end else begin
                        n.ps = cfg.prescale_value;
                        if (s.count == `CNT_ZERO) begin
                            n.count = cfg.interval_load_value;
                            n.evt.timeout = 1'b1;
                            n.evt.stop = cfg.mode.timer_mode_field == `MODE_ONESHOT;
                        end else begin
                            n.count = dec;
                        end
                    end
                end
                HM_COUNT: begin
                    n.ps = '0;
                    if (hit) begin
                        if (dec == cfg.match_value) begin
                            n.count = cfg.interval_load_value;
                            n.evt.match = 1'b1;
                            n.evt.stop = 1'b1;
                        end else begin
                            n.count = dec;
                        end
                    end
                end
                HM_TIME, HM_PWM: begin
                    n.ps = '0;
                    n.count = (s.count == `CNT_ZERO) ? cfg.interval_load_value : dec;
                    if (mode == HM_TIME && hit) begin
                        n.captured = s.count;
                        n.evt.capture = 1'b1;
                    end
                    // Pulse mode raises no timeout, match or capture event.
                    if (mode == HM_PWM) begin
                        if (s.count == cfg.interval_load_value) begin
                            n.level = 1'b1;
                        end else if (s.count == cfg.match_value) begin
                            n.level = 1'b0;
                        end
                    end
                end
                HM_IDLE: begin
                    n.ps = '0;
                end
            endcase
        end
        // Registered pin drive keeps the output free of decode glitches.
        n.pin_out = n.level ^ cfg.pulse_output_invert;
        n.pin_oe = mode == HM_PWM;
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.count <= `CNT_RST;
            s.captured <= `CNT_RST;
        end else begin
            s <= n;
        end
    end

    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign evt = s.evt;
    assign count_view = (mode == HM_TIME) ? s.captured : s.count;

endmodule : timer_half

/* File: hw/timer_top.sv */
// Timer pair with APB register file, 32-bit and real-time clock counters.
//
// Behaviour
// - Prescaler is bypassed in edge count, edge time and pulse modes.
// - Capture select clear gives edge counting down, on chosen edge kinds.
// - Each chosen edge decrements; at the match value raw and masked match flags set.
// - On match the count reloads, enable clears, further edges are ignored.
// - Edge time mode free-runs down from load value, 0xFFFF after reset.
// - Capture select set gives edge time mode with chosen edge kinds.
// - On each chosen edge the count is captured and capture flags set.
// - Edge time counter keeps running and reloads at zero.
// - Captured count holds until the next chosen edge overwrites it.
// - Pulse mode counts down to zero, reloads next cycle, repeats while enabled.
// - Pulse mode sets no status or interrupt flag.
// - Pulse goes active at load value, inactive at match, updated synchronously.
// - The invert bit flips the pulse output polarity.
// - Real-time clock match sets its raw flag and counting continues.
// - Writing one to a clear bit clears raw and masked flag.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "timer_map.svh"

module timer_top #(
    // Last value of the real-time clock divider: rising pin edges per tick, minus one.
    parameter logic [14:0] RTC_TICK_LAST = `RTC_DIV_LAST
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire timer_pkg::apb_req_t apb_req,
    output timer_pkg::apb_rsp_t apb_rsp,
    // Capture/compare pins, index 0 is half A (the even pin)
    input wire logic [1:0] ccp_in,
    output logic [1:0] ccp_out,
    output logic [1:0] ccp_oe
);
    import timer_pkg::*;

    main_state_t s;
    main_state_t n;
    half_cfg_t hcfg [2];
    half_evt_t hevt [2];
    logic [15:0] hview [2];
    logic [15:0] hset;
    logic [15:0] hclr;
    logic [31:0] rdata;
    logic hit;
    logic setup;
    logic wr;
    logic is32;
    logic [31:0] load32;
    logic [31:0] mat32;

    assign setup = apb_req.psel && !apb_req.penable;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign is32 = s.cfg != `CFG_16;
    assign load32 = {s.ilr[1], s.ilr[0]};
    assign mat32 = {s.mat[1], s.mat[0]};

    // Both halves share one structure; each sees its own slice of the control word.
    for (genvar i = 0; i < 2; i++) begin : g_half
        assign hcfg[i] = '{
            sixteen: s.cfg == `CFG_16,
            enable: s.ctl[`CTL_EN + `HALF_STEP * i],
            mode: s.hmode[i],
            edge_event_select: s.ctl[`CTL_EVT + `HALF_STEP * i +: 2],
            pulse_output_invert: s.ctl[`CTL_INV + `HALF_STEP * i],
            interval_load_value: s.ilr[i],
            match_value: s.mat[i],
            prescale_value: s.pr[i],
            load_strobe: s.ld[i]
        };

        timer_half u_half (
            .clk(clk),
            .arst_n(arst_n),
            .cfg(hcfg[i]),
            .pin_in(ccp_in[i]),
            .pin_out(ccp_out[i]),
            .pin_oe(ccp_oe[i]),
            .count_view(hview[i]),
            .evt(hevt[i])
        );
    end

    // Read decode; an unlisted or unaligned address answers with an error.
    always_comb begin
        rdata = '0;
        hit = 1'b1;
        unique case (apb_req.paddr)
            `OFS_CFG: rdata[2:0] = s.cfg;
            `OFS_AMODE: rdata[3:0] = s.hmode[0];
            `OFS_BMODE: rdata[3:0] = s.hmode[1];
            `OFS_CTL: rdata[15:0] = s.ctl;
            `OFS_IMR: rdata[15:0] = s.imr;
            `OFS_RIS: rdata[15:0] = s.ris;
            `OFS_MIS: rdata[15:0] = s.ris & s.imr;
            `OFS_ICR: rdata = '0;
            `OFS_AILR: rdata = is32 ? load32 : {16'h0000, s.ilr[0]};
            `OFS_BILR: rdata[15:0] = s.ilr[1];
            `OFS_AMAT: rdata = is32 ? mat32 : {16'h0000, s.mat[0]};
            `OFS_BMAT: rdata[15:0] = s.mat[1];
            `OFS_APR: rdata[7:0] = s.pr[0];
            `OFS_BPR: rdata[7:0] = s.pr[1];
            `OFS_ACNT: rdata = is32 ? s.cnt32 : {16'h0000, hview[0]};
            `OFS_BCNT: rdata[15:0] = is32 ? s.cnt32[31:16] : hview[1];
            default: hit = 1'b0;
        endcase
    end

    // Next state: counters, flags, then the bus write, which wins over
    // a hardware clear of an enable bit in the same cycle.
    always_comb begin
        n = s;
        n.ld = 2'b00;
        hset = '0;
        hclr = '0;

        // 32-bit one-shot or periodic down-counter.
        if (s.cfg == `CFG_32) begin
            if (s.ld[0]) begin
                n.cnt32 = load32;
            end else if (s.ctl[`CTL_EN] && (s.hmode[0].timer_mode_field == `MODE_ONESHOT ||
                                            s.hmode[0].timer_mode_field == `MODE_PERIODIC)) begin
                if (s.cnt32 == `CNT32_ZERO) begin
                    n.cnt32 = load32;
                    hset[`RIS_TO] = 1'b1;
                    if (s.hmode[0].timer_mode_field == `MODE_ONESHOT) begin
                        n.ctl[`CTL_EN] = 1'b0;
                    end
                end else begin
                    n.cnt32 = s.cnt32 - `CNT32_ONE;
                end
            end
        end

        // Real-time clock: rising edges of the even pin are divided to one
        // tick per second; a tick that finds the count at the match wraps it to zero.
        if (s.cfg == `CFG_RTC && s.ctl[`CTL_EN] && hevt[0].rise) begin
            if (s.div != RTC_TICK_LAST) begin
                n.div = s.div + `RTC_DIV_ONE;
            end else begin
                n.div = '0;
                if (s.cnt32 == mat32) begin
                    n.cnt32 = `CNT32_ZERO;
                    hset[`RIS_RTC] = 1'b1;
                end else begin
                    n.cnt32 = s.cnt32 + `CNT32_ONE;
                end
            end
        end

        // Events from the 16-bit halves; a finished edge count stops itself.
        for (int i = 0; i < 2; i++) begin
            hset[`RIS_TO + `HALF_STEP * i] = hset[`RIS_TO + `HALF_STEP * i] | hevt[i].timeout;
            hset[`RIS_CM + `HALF_STEP * i] = hevt[i].match;
            hset[`RIS_CE + `HALF_STEP * i] = hevt[i].capture;
            if (hevt[i].stop) begin
                n.ctl[`CTL_EN + `HALF_STEP * i] = 1'b0;
            end
        end

        // Read data is captured in the setup phase and shown in the access phase.
        if (setup) begin
            n.prdata = rdata;
            n.slverr = !hit;
        end

        // Register writes take effect at the access-phase edge.
        if (wr && hit) begin
            unique case (apb_req.paddr)
                `OFS_CFG: begin
                    n.cfg = apb_req.pwdata[2:0];
                    if (apb_req.pwdata[2:0] == `CFG_RTC) begin
                        n.cnt32 = `RTC_FIRST;
                        n.div = '0;
                    end
                end
                `OFS_AMODE: n.hmode[0] = apb_req.pwdata[3:0];
                `OFS_BMODE: n.hmode[1] = apb_req.pwdata[3:0];
                `OFS_CTL: n.ctl = apb_req.pwdata[15:0] & `CTL_BITS;
                `OFS_IMR: n.imr = apb_req.pwdata[15:0] & `RIS_BITS;
                `OFS_ICR: hclr = apb_req.pwdata[15:0];
                `OFS_AILR: begin
                    n.ilr[0] = apb_req.pwdata[15:0];
                    if (is32) begin
                        n.ilr[1] = apb_req.pwdata[31:16];
                    end
                    n.ld[0] = 1'b1;
                end
                `OFS_BILR: begin
                    n.ilr[1] = apb_req.pwdata[15:0];
                    n.ld[1] = 1'b1;
                end
                `OFS_AMAT: begin
                    n.mat[0] = apb_req.pwdata[15:0];
                    if (is32) begin
                        n.mat[1] = apb_req.pwdata[31:16];
                    end
                end
                `OFS_BMAT: n.mat[1] = apb_req.pwdata[15:0];
                `OFS_APR: n.pr[0] = apb_req.pwdata[7:0];
                `OFS_BPR: n.pr[1] = apb_req.pwdata[7:0];
                default: begin
                end
            endcase
        end

        // A flag raised in the cycle it is cleared survives; masked view follows raw.
        n.ris = ((s.ris & ~hclr) | hset) & `RIS_BITS;
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.ilr[0] <= `CNT_RST;
            s.ilr[1] <= `CNT_RST;
            s.mat[0] <= `CNT_RST;
            s.mat[1] <= `CNT_RST;
            s.cnt32 <= {`CNT_RST, `CNT_RST}; // Both counter halves wake all ones.
        end else begin
            s <= n;
        end
    end

    // The slave never inserts wait states.
    assign apb_rsp.prdata = s.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = s.slverr && apb_req.psel && apb_req.penable;

endmodule : timer_top

/* File: tb/edge_source.sv */
// Behavioural source of edges on one capture pin.
`timescale 1ns/10ps

module edge_source (
    // Clock
    input wire logic clk,
    // Pin driven into the timer
    output logic pin
);
    initial pin = 1'b0;

    // Each level is held at least two clocks, otherwise the timer may miss it.
    task automatic toggle(input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            pin <= ~pin;
            repeat ((hold < 2) ? 2 : hold) @(posedge clk);
        end
    endtask : toggle
endmodule : edge_source

/* File: tb/tb.sv */
// Self-checking bench for the timer pair.
`timescale 1ns/10ps
`include "timer_map.svh"

module tb;
    import timer_pkg::*;
    logic clk;
    logic arst_n;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    wire [1:0] ccp_in;
    logic [1:0] ccp_out;
    logic [1:0] ccp_oe;
    logic [31:0] rdata;
    logic [31:0] r1;
    logic rerr;
    int n_errors;
    int total_checks;
    int hi;
    logic [1:0] codes [3] = '{`EVT_RISE, `EVT_FALL, `EVT_BOTH};
    logic exp1 [3] = '{1'b1, 1'b0, 1'b1};
    logic exp2 [3] = '{1'b0, 1'b1, 1'b1};

    // Clock at 125 MHz.
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // Four rising pin edges per real-time clock tick keep that test short.
    timer_top #(.RTC_TICK_LAST(15'h0003)) uut (.clk(clk), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe));
    edge_source src_a (.clk(clk), .pin(ccp_in[0]));
    edge_source src_b (.clk(clk), .pin(ccp_in[1]));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high.
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : access

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        access(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        access(1'b0, a, 32'h0000_0000);
        check(rdata, want);
    endtask : rd

    // High cycles of pulse output A over two 21-cycle periods.
    task automatic count_high;
        hi = 0;
        repeat (42) begin
            @(posedge clk);
            if (ccp_out[0] === 1'b1) hi++;
        end
    endtask : count_high

    task automatic complete_run;
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // Watchdog, far beyond the fewer than one thousand cycles the tests need.
    initial begin
        #160000;
        n_errors++;
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        apb_req = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        // The block clock is taken as already ungated; a few idle cycles stand in for that step.
        repeat (3) @(posedge clk);
        // Reset values, a refused address and a read-only status register.
        rd(`OFS_AILR, 32'hFFFF_FFFF);
        rd(`OFS_ACNT, 32'hFFFF_FFFF);
        rd(`OFS_CFG, 32'h0000_0000);
        access(1'b0, 12'h040, 32'h0000_0000);
        check({31'h0, rerr}, 32'h0000_0001);
        wr(`OFS_RIS, 32'hFFFF_FFFF);
        rd(`OFS_RIS, 32'h0000_0000);
        // Edge count on A, both edges, load 10, match 6, prescaler set but bypassed.
        wr(`OFS_CFG, 32'h0000_0004);
        wr(`OFS_AMODE, 32'h0000_0003);
        wr(`OFS_AILR, 32'h0000_000A);
        wr(`OFS_AMAT, 32'h0000_0006);
        wr(`OFS_APR, 32'h0000_0005);
        wr(`OFS_IMR, 32'h0000_0002);
        wr(`OFS_CTL, 32'h0000_000D);
        src_a.toggle(2, 4);
        rd(`OFS_ACNT, 32'h0000_0008);
        src_a.toggle(2, 4);
        repeat (6) @(posedge clk);
        rd(`OFS_RIS, 32'h0000_0002);
        rd(`OFS_MIS, 32'h0000_0002);
        rd(`OFS_CTL, 32'h0000_000C);
        src_a.toggle(2, 4);
        rd(`OFS_ACNT, 32'h0000_000A);
        wr(`OFS_ICR, 32'h0000_0002);
        rd(`OFS_RIS, 32'h0000_0000);
        rd(`OFS_MIS, 32'h0000_0000);
        // Edge time on B for every edge kind; one rising and one falling edge each.
        wr(`OFS_BMODE, 32'h0000_0007);
        wr(`OFS_IMR, 32'h0000_0400);
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_CTL, 32'h0000_0100 | (32'(codes[i]) << 10));
            src_b.toggle(1, 4);
            repeat (6) @(posedge clk);
            access(1'b0, `OFS_MIS, 32'h0000_0000);
            check({31'h0, rdata[10]}, {31'h0, exp1[i]});
            wr(`OFS_ICR, 32'h0000_0400);
            src_b.toggle(1, 4);
            repeat (6) @(posedge clk);
            access(1'b0, `OFS_RIS, 32'h0000_0000);
            check({31'h0, rdata[10]}, {31'h0, exp2[i]});
            wr(`OFS_ICR, 32'h0000_0400);
        end
        // Captured count stands still, then a new edge captures a lower count.
        access(1'b0, `OFS_BCNT, 32'h0000_0000);
        r1 = rdata;
        check({31'h0, r1 < 32'h0000_FFFF}, 32'h0000_0001);
        repeat (30) @(posedge clk);
        rd(`OFS_BCNT, r1);
        src_b.toggle(1, 4);
        repeat (6) @(posedge clk);
        access(1'b0, `OFS_BCNT, 32'h0000_0000);
        check({31'h0, rdata < r1}, 32'h0000_0001);
        // A short load passes zero long before the edge; without the reload the capture would be near 0xFFFF.
        wr(`OFS_BILR, 32'h0000_0008);
        repeat (20) @(posedge clk);
        src_b.toggle(1, 4);
        repeat (6) @(posedge clk);
        access(1'b0, `OFS_BCNT, 32'h0000_0000);
        check({31'h0, rdata <= 32'h0000_0008}, 32'h0000_0001);
        // Pulse output on A: period 21, active from load 20 down to match 10.
        wr(`OFS_CTL, 32'h0000_0000);
        wr(`OFS_ICR, 32'h0000_FFFF);
        wr(`OFS_AMODE, 32'h0000_000A);
        wr(`OFS_AILR, 32'h0000_0014);
        wr(`OFS_AMAT, 32'h0000_000A);
        wr(`OFS_CTL, 32'h0000_0001);
        repeat (30) @(posedge clk);
        check({30'h0, ccp_oe}, 32'h0000_0001);
        count_high();
        check(hi, 32'd20);
        wr(`OFS_CTL, 32'h0000_0041);
        repeat (4) @(posedge clk);
        count_high();
        check(hi, 32'd22);
        rd(`OFS_RIS, 32'h0000_0000);
        // 32-bit one-shot from 16 times out once, reloads and clears its own enable; periodic keeps it.
        wr(`OFS_CTL, 32'h0000_0000);
        wr(`OFS_CFG, 32'h0000_0000);
        wr(`OFS_AMODE, 32'h0000_0001);
        wr(`OFS_AILR, 32'h0000_0010);
        wr(`OFS_IMR, 32'h0000_0001);
        wr(`OFS_CTL, 32'h0000_0001);
        repeat (40) @(posedge clk);
        rd(`OFS_RIS, 32'h0000_0001);
        rd(`OFS_CTL, 32'h0000_0000);
        rd(`OFS_ACNT, 32'h0000_0010);
        wr(`OFS_ICR, 32'h0000_0001);
        wr(`OFS_AMODE, 32'h0000_0002);
        wr(`OFS_CTL, 32'h0000_0001);
        repeat (40) @(posedge clk);
        rd(`OFS_RIS, 32'h0000_0001);
        rd(`OFS_CTL, 32'h0000_0001);
        // 16-bit periodic on B with a prescaler keeps its enable after each timeout.
        wr(`OFS_CTL, 32'h0000_0000);
        wr(`OFS_ICR, 32'h0000_FFFF);
        wr(`OFS_CFG, 32'h0000_0004);
        wr(`OFS_BMODE, 32'h0000_0002);
        wr(`OFS_BPR, 32'h0000_0001);
        wr(`OFS_BILR, 32'h0000_0003);
        wr(`OFS_CTL, 32'h0000_0100);
        repeat (40) @(posedge clk);
        rd(`OFS_RIS, 32'h0000_0100);
        rd(`OFS_CTL, 32'h0000_0100);
        // Real-time clock, four rises a tick: 1 becomes 2, then the match at 2 wraps to 0 and flags.
        wr(`OFS_CTL, 32'h0000_0000);
        wr(`OFS_ICR, 32'h0000_FFFF);
        wr(`OFS_CFG, 32'h0000_0001);
        rd(`OFS_ACNT, 32'h0000_0001);
        wr(`OFS_AMAT, 32'h0000_0002);
        wr(`OFS_IMR, 32'h0000_0008);
        wr(`OFS_CTL, 32'h0000_0011);
        src_a.toggle(16, 2);
        repeat (6) @(posedge clk);
        rd(`OFS_RIS, 32'h0000_0008);
        rd(`OFS_MIS, 32'h0000_0008);
        rd(`OFS_ACNT, 32'h0000_0000);
        src_a.toggle(8, 2);
        repeat (6) @(posedge clk);
        rd(`OFS_ACNT, 32'h0000_0001);
        complete_run();
    end
endmodule : tb

/* File: tb/timer_checker.sv */
// Port-level assertions for the timer pair.
`timescale 1ns/10ps
`include "timer_map.svh"

module timer_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave side
    input wire timer_pkg::apb_req_t apb_req,
    input wire timer_pkg::apb_rsp_t apb_rsp,
    // Capture/compare pins
    input wire logic [1:0] ccp_in,
    input wire logic [1:0] ccp_out,
    input wire logic [1:0] ccp_oe
);
    import timer_pkg::*;
    logic acc;
    logic rd;
    logic ok;
    logic [2:0] age_reg;
    logic [2:0] up_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Access phase, read access and address decode.
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    assign ok = apb_req.paddr inside {`OFS_CFG, `OFS_AMODE, `OFS_BMODE, `OFS_CTL, `OFS_IMR, `OFS_RIS,
        `OFS_MIS, `OFS_ICR, `OFS_AILR, `OFS_BILR, `OFS_AMAT, `OFS_BMAT, `OFS_APR, `OFS_BPR, `OFS_ACNT, `OFS_BCNT};

    // Saturating ages since the last write and since reset; a pin enable may only follow setup.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            age_reg <= 3'h7;
            up_reg <= 3'h0;
        end else begin
            age_reg <= (acc && apb_req.pwrite) ? 3'h0 : ((age_reg == 3'h7) ? age_reg : age_reg + 3'h1);
            up_reg <= (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
        end
    end

    AST_READY: assert property (apb_rsp.pready) else $error("pready low");
    AST_ERR_PHASE: assert property (apb_rsp.pslverr |-> acc) else $error("pslverr outside access");
    AST_UNMAPPED: assert property (rd && !ok |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    AST_MAPPED: assert property (acc && ok |-> !apb_rsp.pslverr) else $error("mapped access refused");
    AST_ICR_ZERO: assert property (rd && apb_req.paddr == `OFS_ICR |-> apb_rsp.prdata == 32'h0000_0000)
        else $error("clear register read not zero");
    AST_RIS_RSVD: assert property (rd && apb_req.paddr inside {`OFS_RIS, `OFS_MIS}
        |-> (apb_rsp.prdata & ~{16'h0000, `RIS_BITS}) == 32'h0000_0000) else $error("status spare bit set");
    AST_CTL_RSVD: assert property (rd && apb_req.paddr == `OFS_CTL
        |-> (apb_rsp.prdata & ~{16'h0000, `CTL_BITS}) == 32'h0000_0000) else $error("control spare bit set");
    AST_HOLD: assert property ($changed(apb_rsp.prdata) |-> $past(apb_req.psel && !apb_req.penable))
        else $error("read data moved outside setup");
    AST_OE_CAUSE: assert property ($rose(ccp_oe[0]) || $rose(ccp_oe[1]) |-> age_reg <= 3'h3)
        else $error("pin enable without setup");
    AST_WAKE: assert property (up_reg < 3'h2 |-> ccp_oe == 2'h0 && !apb_rsp.pslverr)
        else $error("outputs active after reset");
endmodule : timer_checker

bind timer_top timer_checker chk (.clk(clk), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe));
